//--- hdl/gate_link_pkg.sv
// Shared constants and types for the three-phase gate input link
package gate_link_pkg;
	// Number of phases driven
	localparam int PHASE_COUNT = 3;
	// Serial frame length in bits
	localparam int FRAME_BITS = 8;
	// Device clock rate in MHz
	localparam int CLK_MHZ = 200;
	// Typical serial clock rate in kHz
	localparam int SCLK_KHZ = 3000;
	// Half period of the serial clock, in device clocks, rounded down
	localparam int SCLK_HALF_CYCLES = (CLK_MHZ * 1000) / (2 * SCLK_KHZ);
	// Longest time from reset to logic reset, in ns
	localparam int RESET_REACT_NS = 77;
	// Cycles allowed for that reaction, rounded down, at least one
	localparam int RESET_REACT_CYCLES = (RESET_REACT_NS * CLK_MHZ / 1000) < 1 ? 1 :
		(RESET_REACT_NS * CLK_MHZ / 1000);
	// Bootstrap charge pulse length in device clocks
	localparam int BOOT_PULSE_CYCLES = 16;
	// Reset values
	localparam logic [2:0] UPPER_IDLE_N = 3'h7;
	localparam logic [2:0] LOWER_IDLE = 3'h0;
	// Host sequencing states
	typedef enum logic [1:0] {
		HOST_IDLE = 2'b00,
		HOST_SHIFT_HI = 2'b01,
		HOST_SHIFT_LO = 2'b10,
		HOST_DONE = 2'b11
	} host_state_e;
endpackage

//--- hdl/gate_link_if.sv
// Pin-level interface between the controller and the gate driver
`timescale 1ns/100ps
interface gate_link_if;
	// Enables
	logic gateEnableFirst;
	logic gateEnableSecond;
	// Phase commands, upper active low, lower active high
	logic [2:0] upperCmdN;
	logic [2:0] lowerCmd;
	// Status outputs from the device
	logic [2:0] levelFlag;
	logic overcurrentFlagOut;
	// Serial port
	logic chipSelectN;
	logic serialClk;
	logic serialIn;
	logic serialOut;
	logic serialOutEnN;
	// Serial output as the controller sees it; a released line shows the inverse
	// of the last bit, so a sample taken while deselected never passes for data
	logic serialOutWire;
	assign serialOutWire = serialOutEnN ? ~serialOut : serialOut;
	// Device reset pin, active low
	logic resetPinN;
	modport device (
		input gateEnableFirst, gateEnableSecond, upperCmdN, lowerCmd,
		input chipSelectN, serialClk, serialIn, resetPinN,
		output levelFlag, overcurrentFlagOut, serialOut, serialOutEnN
	);
	modport host (
		output gateEnableFirst, gateEnableSecond, upperCmdN, lowerCmd,
		output chipSelectN, serialClk, serialIn, resetPinN,
		input levelFlag, overcurrentFlagOut, serialOutWire
	);
endinterface

//--- hdl/gate_driver_device.sv
// Device end: gate command qualification, status outputs and serial port pins
//
// Operation
// - Gates drive only while both enables high
// - Upper gate on when its command low
// - Lower gate on when its command high
// - Level flag low below half load supply
// - Overcurrent result shown on push-pull output
// - Serial port active only while selected
// - Input sampled falling clock edge, MSB first
// - Serial output high impedance until selected
// - Controller runs serial clock near 3 MHz
// - Enable low forces gates off, logic runs
// - Controller pulses lower before upper after enable
// - Reset low disables outputs within 77 ns
`timescale 1ns/100ps
module gate_driver_device
	import gate_link_pkg::*;
#(
	parameter int FRAME_LEN = FRAME_BITS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Link to controller
	gate_link_if.device link,
	// Analog comparator results, from outside the clock domain
	input wire logic [2:0] upperSourceAboveHalf,
	input wire logic overcurrentDetect,
	// Reply word loaded at frame start
	input wire logic [FRAME_BITS-1:0] replyWord,
	// Gate drive outputs
	output logic [2:0] upperGateOn,
	output logic [2:0] lowerGateOn,
	// Received serial word and its strobe
	output logic [FRAME_BITS-1:0] rxWord,
	output logic rxValid
);
	// Elaboration check: the shifters are built for the package frame length only
	if (FRAME_LEN != FRAME_BITS) begin : g_bad_frame_len
		$error("FRAME_LEN must equal FRAME_BITS");
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: two flops before any logic
	localparam int SYNC_W = 13;
	logic [SYNC_W-1:0] syncA_r; // First stage, read only by second
	logic [SYNC_W-1:0] syncB_r; // Second stage, usable
	logic [SYNC_W-1:0] pinBus; // Gathered pins
	assign pinBus = {link.resetPinN, link.gateEnableFirst, link.gateEnableSecond,
		link.upperCmdN, link.lowerCmd, link.chipSelectN, link.serialClk,
		link.serialIn, overcurrentDetect};
	// Both stages reset to idle-safe levels
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			syncA_r <= {1'b0, 2'b00, UPPER_IDLE_N, LOWER_IDLE, 1'b1, 1'b0, 1'b0, 1'b0};
			syncB_r <= {1'b0, 2'b00, UPPER_IDLE_N, LOWER_IDLE, 1'b1, 1'b0, 1'b0, 1'b0};
		end else begin
			syncA_r <= pinBus;
			syncB_r <= syncA_r;
		end
	end
	logic pinResetN; // Synchronised reset pin
	logic enFirst; // Synchronised enables
	logic enSecond;
	logic [2:0] upperN; // Synchronised commands
	logic [2:0] lower;
	logic csN; // Synchronised select
	logic sclk; // Synchronised serial clock
	logic sdi; // Synchronised serial data
	logic ocSync; // Synchronised overcurrent
	assign {pinResetN, enFirst, enSecond, upperN, lower, csN, sclk, sdi, ocSync} = syncB_r;

	// Level flags synchronised separately
	logic [2:0] lvlA_r;
	logic [2:0] lvlB_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lvlA_r <= 3'h0;
			lvlB_r <= 3'h0;
		end else begin
			lvlA_r <= upperSourceAboveHalf;
			lvlB_r <= lvlA_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Gate command qualification
	logic gatesAllowed;
	assign gatesAllowed = enFirst & enSecond & pinResetN;
	// Registered drives; a slip through an enable edge costs one extra cycle only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			upperGateOn <= 3'h0;
			lowerGateOn <= 3'h0;
		end else begin
			upperGateOn <= gatesAllowed ? ~upperN : 3'h0;
			lowerGateOn <= gatesAllowed ? lower : 3'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status outputs, totem pole, so always driven
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			link.levelFlag <= 3'h0;
			link.overcurrentFlagOut <= 1'b0;
		end else if (!pinResetN) begin
			link.levelFlag <= 3'h0;
			link.overcurrentFlagOut <= 1'b0;
		end else begin
			link.levelFlag <= lvlB_r;
			link.overcurrentFlagOut <= ocSync;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial clock edge detection
	logic sclkPrev_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) sclkPrev_r <= 1'b0;
		else sclkPrev_r <= sclk;
	end
	logic sclkFall;
	logic sclkRise;
	assign sclkFall = sclkPrev_r & ~sclk;
	assign sclkRise = ~sclkPrev_r & sclk;
	logic csPrev_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) csPrev_r <= 1'b1;
		else csPrev_r <= csN;
	end
	logic frameStart;
	assign frameStart = csPrev_r & ~csN;
	logic portActive;
	assign portActive = ~csN & pinResetN;

	////////////////////////////////////////////////////////////////////////////
	// Receive shifter
	logic [FRAME_BITS-1:0] rxShift_r;
	logic [3:0] bitCount_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rxShift_r <= '0;
			bitCount_r <= 4'h0;
			rxWord <= '0;
			rxValid <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			if (!portActive) begin
				// Idle: frame aborted or not yet begun
				bitCount_r <= 4'h0;
			end else if (sclkFall) begin
				rxShift_r <= {rxShift_r[FRAME_BITS-2:0], sdi};
				if (bitCount_r == 4'(FRAME_BITS - 1)) begin
					rxWord <= {rxShift_r[FRAME_BITS-2:0], sdi};
					rxValid <= 1'b1;
					bitCount_r <= 4'h0;
				end else begin
					bitCount_r <= bitCount_r + 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit shifter, changes on rising edge so the far end samples on falling
	logic [FRAME_BITS-1:0] txShift_r;
	logic txStarted_r; // First rising edge keeps MSB
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			txShift_r <= '0;
			txStarted_r <= 1'b0;
		end else if (frameStart) begin
			txShift_r <= replyWord;
			txStarted_r <= 1'b0;
		end else if (portActive && sclkRise) begin
			if (txStarted_r) txShift_r <= {txShift_r[FRAME_BITS-2:0], 1'b0};
			txStarted_r <= 1'b1;
		end
	end
	// Output drive and enable, enable low means driving
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			link.serialOut <= 1'b0;
			link.serialOutEnN <= 1'b1;
		end else begin
			link.serialOut <= frameStart ? replyWord[FRAME_BITS-1] : txShift_r[FRAME_BITS-1];
			link.serialOutEnN <= ~portActive;
		end
	end
endmodule // gate_driver_device

//--- hdl/gate_controller_host.sv
// Controller end: drives enables, phase commands and serial frames
`timescale 1ns/100ps
module gate_controller_host
	import gate_link_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Link to device
	gate_link_if.host link,
	// User commands
	input wire logic enableReq,
	input wire logic [2:0] upperReq,
	input wire logic [2:0] lowerReq,
	input wire logic sendReq,
	input wire logic [FRAME_BITS-1:0] sendWord,
	// User status
	output logic busy,
	output logic [FRAME_BITS-1:0] replyWord,
	output logic replyValid,
	output logic [2:0] levelSeen
);
	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers for device outputs
	logic [4:0] syA_r;
	logic [4:0] syB_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			syA_r <= 5'h00;
			syB_r <= 5'h00;
		end else begin
			syA_r <= {link.levelFlag, link.overcurrentFlagOut, link.serialOutWire};
			syB_r <= syA_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Enable and bootstrap sequencing
	logic [4:0] bootCount_r; // Lower pulse timer after enable
	logic bootDone_r;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bootCount_r <= 5'h00;
			bootDone_r <= 1'b0;
			link.gateEnableFirst <= 1'b0;
			link.gateEnableSecond <= 1'b0;
			link.resetPinN <= 1'b0;
			link.upperCmdN <= UPPER_IDLE_N;
			link.lowerCmd <= LOWER_IDLE;
			levelSeen <= 3'h0;
		end else begin
			link.resetPinN <= 1'b1;
			link.gateEnableFirst <= enableReq;
			link.gateEnableSecond <= enableReq;
			levelSeen <= syB_r[4:2];
			if (!enableReq) begin
				bootCount_r <= 5'h00;
				bootDone_r <= 1'b0;
				link.upperCmdN <= UPPER_IDLE_N;
				link.lowerCmd <= LOWER_IDLE;
			end else if (!bootDone_r) begin
				link.upperCmdN <= UPPER_IDLE_N;
				link.lowerCmd <= 3'h7;
				bootCount_r <= bootCount_r + 5'h01;
				if (bootCount_r == 5'(BOOT_PULSE_CYCLES - 1)) bootDone_r <= 1'b1;
			end else begin
				// User commands, never both switches of a phase
				link.upperCmdN <= ~(upperReq & ~lowerReq);
				link.lowerCmd <= lowerReq;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial clock divider and frame sequencer
	logic [7:0] divCount_r;
	logic [3:0] bitIdx_r;
	logic [FRAME_BITS-1:0] txShift_r;
	logic [FRAME_BITS-1:0] rxShift_r;
	host_state_e state_r;
	logic halfTick;
	assign halfTick = divCount_r == 8'(SCLK_HALF_CYCLES - 1);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) divCount_r <= 8'h00;
		else if (state_r == HOST_IDLE || halfTick) divCount_r <= 8'h00;
		else divCount_r <= divCount_r + 8'h01;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= HOST_IDLE;
			bitIdx_r <= 4'h0;
			txShift_r <= '0;
			rxShift_r <= '0;
			link.chipSelectN <= 1'b1;
			link.serialClk <= 1'b0;
			link.serialIn <= 1'b0;
			busy <= 1'b0;
			replyWord <= '0;
			replyValid <= 1'b0;
		end else begin
			replyValid <= 1'b0;
			unique case (state_r)
				HOST_IDLE: begin
					if (sendReq) begin
						link.chipSelectN <= 1'b0;
						link.serialIn <= sendWord[FRAME_BITS-1];
						txShift_r <= {sendWord[FRAME_BITS-2:0], 1'b0};
						bitIdx_r <= 4'h0;
						busy <= 1'b1;
						state_r <= HOST_SHIFT_HI;
					end
				end
				HOST_SHIFT_HI: if (halfTick) begin
					link.serialClk <= 1'b1;
					// next bit at rise
					// Data moves on the rise so it stands still across the sampling fall
					if (bitIdx_r != 4'h0) begin
						link.serialIn <= txShift_r[FRAME_BITS-1];
						txShift_r <= {txShift_r[FRAME_BITS-2:0], 1'b0};
					end
					state_r <= HOST_SHIFT_LO;
				end
				HOST_SHIFT_LO: if (halfTick) begin
					// Falling edge: device samples, host samples reply
					link.serialClk <= 1'b0;
					rxShift_r <= {rxShift_r[FRAME_BITS-2:0], syB_r[0]};
					if (bitIdx_r == 4'(FRAME_BITS - 1)) begin
						state_r <= HOST_DONE;
					end else begin
						bitIdx_r <= bitIdx_r + 4'h1;
						state_r <= HOST_SHIFT_HI;
					end
				end
				HOST_DONE: if (halfTick) begin
					link.chipSelectN <= 1'b1;
					replyWord <= rxShift_r;
					replyValid <= 1'b1;
					busy <= 1'b0;
					state_r <= HOST_IDLE;
				end
			endcase
		end
	end
endmodule // gate_controller_host

//--- testbench/gate_link_chk.sv
// Pin checks between controller and gate driver
`timescale 1ns/100ps
module gate_link_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Controller pins
	input wire logic gateEnableFirst,
	input wire logic [2:0] upperCmdN,
	input wire logic [2:0] lowerCmd,
	input wire logic chipSelectN,
	input wire logic serialClk,
	input wire logic serialIn,
	input wire logic resetPinN,
	// Driver pins
	input wire logic [2:0] levelFlag,
	input wire logic overcurrentFlagOut,
	input wire logic serialOutEnN
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////
	a_out_released: assert property (chipSelectN [*4] |-> serialOutEnN)
		else $error("serial out driven while deselected");
	a_out_driven: assert property ((!chipSelectN && resetPinN) [*4] |-> !serialOutEnN)
		else $error("serial out not driven while selected");
	a_clock_idle: assert property (chipSelectN |-> !serialClk)
		else $error("serial clock high outside frame");
	a_cs_lead: assert property ($fell(chipSelectN) |-> (!serialClk) [*8])
		else $error("serial clock too soon after select");
	a_high_half: assert property ($rose(serialClk) |-> ##32 serialClk ##1 !serialClk)
		else $error("serial clock high phase wrong");
	a_low_half: assert property ($fell(serialClk) |-> ##32 !serialClk)
		else $error("serial clock low phase short");
	a_data_hold: assert property ($fell(serialClk) |-> $stable(serialIn))
		else $error("serial in moved at sampling edge");
	a_boot_first: assert property ($rose(gateEnableFirst) |->
		##[0:2] (lowerCmd == 3'h7 && upperCmdN == 3'h7) [*8])
		else $error("no lower pulse before upper");
	a_reset_quiet: assert property ((!resetPinN) [*4] |->
		(levelFlag == 3'h0 && !overcurrentFlagOut && serialOutEnN))
		else $error("outputs active while reset pin low");
	// Main scenarios reached
	cover property ($fell(chipSelectN));
	cover property ($rose(gateEnableFirst));
	cover property ($fell(resetPinN));
endmodule // gate_link_chk

//--- testbench/tb_top.sv
// Bench: controller and driver joined, plus a bench-driven second driver
`timescale 1ns/100ps
module tb_top;
	// Clock, resets, counters
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hostHold = 1'b0; // Resets the controller alone
	int n_fail = 0;
	int tests_run = 0;
	int rxPulses = 0; // Receive strobes of the second driver
	// Controller user side
	logic enReq = 1'b0;
	logic [2:0] upReq = 3'h0;
	logic [2:0] loReq = 3'h0;
	logic sendReq = 1'b0;
	logic [7:0] sendWord = 8'h00;
	logic busy, hReplyV;
	logic [7:0] hReply;
	logic [2:0] levelSeen;
	// Comparator inputs and reply word, shared by both drivers
	logic [2:0] srcHi = 3'h0;
	logic ocDet = 1'b0;
	logic [7:0] reply = 8'h00;
	// Driver outputs
	logic [2:0] up1, lo1, up2, lo2;
	logic [7:0] rx1, rx2, soBits;
	logic rxv1, rxv2;
	logic [7:0] sWords [2] = '{8'h3c, 8'h81};
	logic [7:0] rWords [2] = '{8'ha5, 8'h5a};
	////////////////////////////////
	always #2.5 clk = ~clk;
	// Count one-cycle receive strobes of the second driver
	always @(posedge clk) begin
		if (rxv2 === 1'b1) rxPulses <= rxPulses + 1;
	end
	gate_link_if gate_link_if_inst ();
	gate_link_if lk2 (); // Second link, bench plays controller
	gate_controller_host gate_controller_host_inst (.clk(clk), .reset(reset | hostHold),
		.link(gate_link_if_inst), .enableReq(enReq), .upperReq(upReq), .lowerReq(loReq),
		.sendReq(sendReq), .sendWord(sendWord), .busy(busy), .replyWord(hReply),
		.replyValid(hReplyV), .levelSeen(levelSeen));
	gate_driver_device gate_driver_device_inst (.clk(clk), .reset(reset),
		.link(gate_link_if_inst), .upperSourceAboveHalf(srcHi), .overcurrentDetect(ocDet),
		.replyWord(reply), .upperGateOn(up1), .lowerGateOn(lo1), .rxWord(rx1), .rxValid(rxv1));
	gate_driver_device gate_driver_device_inst2 (.clk(clk), .reset(reset), .link(lk2),
		.upperSourceAboveHalf(srcHi), .overcurrentDetect(ocDet), .replyWord(reply),
		.upperGateOn(up2), .lowerGateOn(lo2), .rxWord(rx2), .rxValid(rxv2));
	gate_link_chk gate_link_chk_inst (.clk(clk), .reset(reset),
		.gateEnableFirst(gate_link_if_inst.gateEnableFirst),
		.upperCmdN(gate_link_if_inst.upperCmdN), .lowerCmd(gate_link_if_inst.lowerCmd),
		.chipSelectN(gate_link_if_inst.chipSelectN), .serialClk(gate_link_if_inst.serialClk),
		.serialIn(gate_link_if_inst.serialIn), .resetPinN(gate_link_if_inst.resetPinN),
		.levelFlag(gate_link_if_inst.levelFlag),
		.overcurrentFlagOut(gate_link_if_inst.overcurrentFlagOut),
		.serialOutEnN(gate_link_if_inst.serialOutEnN));
	////////////////////////////////
	// Step n edges, then settle 1 ns
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Value compare, unknowns never match
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bench frame, 125 ns bit time; data moves well after the fall so the sync sees it stable
	task automatic frame(input logic [7:0] w, input int nb);
		lk2.chipSelectN = 1'b0;
		for (int i = 7; i > 7 - nb; i--) begin
			lk2.serialIn = w[i];
			tick(7);
			lk2.serialClk = 1'b1;
			tick(12);
			soBits[i] = lk2.serialOutWire;
			lk2.serialClk = 1'b0;
			tick(6);
		end
		tick(7);
		lk2.chipSelectN = 1'b1;
		tick(8);
	endtask
	// Prints counts and verdict, ends run
	task automatic give_verdict();
		$display("Counts: %0d compared, %0d bad", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////
	// Watchdog, far beyond the expected 9 us
	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end
	// Main sequence
	initial begin
		lk2.gateEnableFirst = 1'b0;
		lk2.gateEnableSecond = 1'b0;
		lk2.upperCmdN = 3'h7;
		lk2.lowerCmd = 3'h0;
		lk2.chipSelectN = 1'b1;
		lk2.serialClk = 1'b0;
		lk2.serialIn = 1'b0;
		lk2.resetPinN = 1'b1;
		tick(10);
		reset = 1'b0;
		tick(2);
		// Gates through the controller
		enReq = 1'b1;
		tick(10);
		chk("boot lower", 8'h07, {5'h0, lo1});
		tick(30);
		upReq = 3'b011;
		loReq = 3'b110;
		tick(8);
		chk("upper gates", 8'h01, {5'h0, up1});
		chk("lower gates", 8'h06, {5'h0, lo1});
		srcHi = 3'b101;
		ocDet = 1'b1;
		tick(8);
		chk("level flags", 8'h05, {5'h0, gate_link_if_inst.levelFlag});
		chk("level seen", 8'h05, {5'h0, levelSeen});
		chk("overcurrent", 8'h01, {7'h0, gate_link_if_inst.overcurrentFlagOut});
		$display("Test done: gates and status");
		// Reset pin low; 5 clocks is well inside 77 ns
		hostHold = 1'b1;
		enReq = 1'b0;
		tick(5);
		chk("reset gates", 8'h00, {2'h0, up1, lo1});
		chk("reset flags", 8'h00, {4'h0, gate_link_if_inst.levelFlag,
			gate_link_if_inst.overcurrentFlagOut});
		hostHold = 1'b0;
		tick(5);
		$display("Test done: reset pin");
		// Back-to-back frames while enables low, so logic still runs
		for (int k = 0; k < 2; k++) begin
			reply = rWords[k];
			sendWord = sWords[k];
			sendReq = 1'b1;
			tick(1);
			sendReq = 1'b0;
			tick(2);
			chk("busy", 8'h01, {7'h0, busy});
			for (int j = 0; j < 1000 && hReplyV !== 1'b1; j++) tick(1);
			chk("host reply", rWords[k], hReply);
			chk("device rx", sWords[k], rx1);
			for (int j = 0; j < 100 && busy !== 1'b0; j++) tick(1);
		end
		$display("Test done: serial frames");
		// Enable table on the second driver, all commands on
		lk2.upperCmdN = 3'h0;
		lk2.lowerCmd = 3'h7;
		for (int e = 0; e < 4; e++) begin
			lk2.gateEnableFirst = e[0];
			lk2.gateEnableSecond = e[1];
			tick(5);
			chk("and upper", (e == 3) ? 8'h07 : 8'h00, {5'h0, up2});
			chk("and lower", (e == 3) ? 8'h07 : 8'h00, {5'h0, lo2});
		end
		// Reset pin alone, enables still high and commands on
		lk2.resetPinN = 1'b0;
		tick(5);
		chk("pin reset upper", 8'h00, {5'h0, up2});
		chk("pin reset lower", 8'h00, {5'h0, lo2});
		chk("pin reset flags", 8'h00, {5'h0, lk2.levelFlag});
		lk2.resetPinN = 1'b1;
		lk2.upperCmdN = 3'b101;
		lk2.lowerCmd = 3'b100;
		tick(5);
		chk("upper b", 8'h02, {5'h0, up2});
		chk("lower c", 8'h04, {5'h0, lo2});
		$display("Test done: enable table");
		// Serial port of second driver, partial frame dropped
		reply = 8'hc6;
		chk("out idle", 8'h01, {7'h0, lk2.serialOutEnN});
		frame(8'h39, 8);
		chk("rx word", 8'h39, rx2);
		chk("rx strobes", 8'h01, 8'(rxPulses));
		chk("out bits", 8'hc6, soBits);
		chk("out released", 8'h01, {7'h0, lk2.serialOutEnN});
		frame(8'hf0, 5);
		chk("partial kept", 8'h39, rx2);
		frame(8'h5e, 8);
		chk("rx after partial", 8'h5e, rx2);
		chk("strobes after partial", 8'h02, 8'(rxPulses));
		$display("Test done: bench serial");
		give_verdict();
	end
endmodule // tb_top
